// ---- hdl/iper_pkg.sv ----
// Constants, field layouts and types of the indirect pointer and environment block.
// Assumes a single core clock and a special-register port driven by the decode stage.
//
// Summary of operation
// - Unimplemented register reads return zero
// - Unimplemented unprotected register writes change nothing
// - Field zero selects matching indirect pointer instead
// - Three independent 8-bit pointers, one per operand
// - Pointer numbers never get stack-pointer offset added
// - Pointers loaded by listed instructions, multiply optional
// - Move-to-special loads pointer from source bits 9-2
// - Move-to-special pointer write takes effect after delay
// - Other loaders set all three from resolved fields
// - Non-move loads check bank protection at load
// - Result pointer: number bits 9-2, zeros below
// - First-source pointer uses same layout
// - Second-source pointer uses same layout
// - Float environment bit 8 selects fast float
// - Bits 7-6 select default rounding mode
// - Bit 5 clear traps float divide by zero
// - Bits 4-2 mask inexact, underflow, overflow traps
// - Bits 1-0 mask reserved-operand and invalid traps
// - Integer bit 1 clear traps divide overflow
// - Integer divide by zero always raises range trap
// - Integer bit 0 clear traps multiply overflow
// - Reserved bits read zero, writes ignored
// - Numbers 128-159 user accessible, 160 up trap
package iper_pkg;

  localparam logic [7:0] SPR_RESULT_PTR = 8'h80;
  localparam logic [7:0] SPR_SOURCE_A_PTR = 8'h81;
  localparam logic [7:0] SPR_SOURCE_B_PTR = 8'h82;
  localparam logic [7:0] SPR_FLOAT_ENV = 8'hA0;
  localparam logic [7:0] SPR_INT_ENV = 8'hA1;
  localparam logic [7:0] SPR_USER_FIRST = 8'h80;
  localparam logic [7:0] SPR_VIRTUAL_FIRST = 8'hA0;

  localparam logic [7:0] GLOBAL_ZERO = 8'h00;
  localparam int PTR_MSB = 9;
  localparam int PTR_LSB = 2;

  localparam int FE_FAST = 8;
  localparam int FE_ROUND_HI = 7;
  localparam int FE_ROUND_LO = 6;
  localparam int FE_MASK_HI = 5;
  localparam int IE_DIV_OVF = 1;
  localparam int IE_MUL_OVF = 0;

  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [8:0] FLOAT_ENV_RESET = 9'h000;
  localparam logic [1:0] INT_ENV_RESET = 2'h0;
  localparam int MTS_DELAY_DEFAULT = 2;

  typedef enum logic [1:0] {
    IPER_RND_NEAREST = 2'b00,
    IPER_RND_MINUS = 2'b01,
    IPER_RND_PLUS = 2'b10,
    IPER_RND_ZERO = 2'b11
  } iper_round_e;

  typedef enum logic [2:0] {
    IPER_CLS_NONE = 3'b000,
    IPER_CLS_SET_POINTERS_INSTR = 3'b001,
    IPER_CLS_EMULATE = 3'b010,
    IPER_CLS_FLOAT = 3'b011,
    IPER_CLS_DIVIDE = 3'b100,
    IPER_CLS_MULTIPLY = 3'b101
  } iper_class_e;

endpackage

// ---- hdl/iper_operand_if.sv ----
// Carries one operand field, its pointer and the stack offset to a resolver.
// Assumes the resolver answers combinationally.
`timescale 1ns/10ps
interface iper_operand_if;
  logic [7:0] field;
  logic [7:0] ptr;
  logic [6:0] sp_off;
  logic [7:0] abs_num;
  modport resolver (input field, input ptr, input sp_off, output abs_num);
  modport user (output field, output ptr, output sp_off, input abs_num);
endinterface

// ---- hdl/iper_resolve.sv ----
// Turns one instruction register field into an absolute register number.
// Assumes the stack offset is bits 8-2 of the stack pointer shadow.
`timescale 1ns/10ps
module iper_resolve (
  iper_operand_if.resolver op
);

  always_comb begin
    if (op.field == iper_pkg::GLOBAL_ZERO) begin
      op.abs_num = op.ptr;
    end else if (op.field[7]) begin
      op.abs_num = {1'b1, 7'(op.field[6:0] + op.sp_off)};
    end else begin
      op.abs_num = op.field;
    end
  end

endmodule

// ---- hdl/iper_top.sv ----
// Indirect pointers and arithmetic environment registers.
// Assumes decode drives all inputs from logic on core_clk.
`timescale 1ns/10ps
module iper_top #(
  parameter int MTS_DELAY = iper_pkg::MTS_DELAY_DEFAULT,
  parameter bit MUL_LOADS_PTRS = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spr_access,
  input wire logic spr_write,
  input wire logic [7:0] spr_num,
  input wire logic [31:0] spr_wdata,
  input wire logic user_mode,
  input wire logic ptr_load,
  input wire iper_pkg::iper_class_e ptr_load_class,
  input wire logic [7:0] first_source_field,
  input wire logic [7:0] second_source_field,
  input wire logic [7:0] destination_field,
  input wire logic [6:0] stack_offset,
  input wire logic [15:0] bank_protect,
  input wire logic [5:0] fp_exc_evt,
  input wire logic int_div_overflow,
  input wire logic int_div_zero,
  input wire logic int_mul_overflow,
  output logic [31:0] spr_rdata_q,
  output logic [7:0] abs_a_q,
  output logic [7:0] abs_b_q,
  output logic [7:0] abs_c_q,
  output logic fast_float_select_q,
  output logic [1:0] float_round_mode_q,
  output logic fp_trap_q,
  output logic range_trap_q,
  output logic prot_trap_q,
  output logic bank_viol_q
);

  if (MTS_DELAY < 1 || MTS_DELAY > 3) begin : g_bad_delay
    $error("MTS_DELAY must lie in 1..3");
  end

  localparam logic [1:0] DELAY_LOAD = 2'(MTS_DELAY);

  typedef struct packed {
    logic [7:0] ptr_a;
    logic [7:0] ptr_b;
    logic [7:0] ptr_c;
    logic [7:0] eff_a;
    logic [7:0] eff_b;
    logic [7:0] eff_c;
    logic [1:0] dly;
    logic [8:0] fenv;
    logic [1:0] ienv;
    logic [31:0] rdata;
    logic [7:0] abs_a;
    logic [7:0] abs_b;
    logic [7:0] abs_c;
    logic fp_trap;
    logic range_trap;
    logic prot_trap;
    logic bank_viol;
  } iper_state_s;

  localparam iper_state_s STATE_RESET = '{
    ptr_a: iper_pkg::PTR_RESET, ptr_b: iper_pkg::PTR_RESET, ptr_c: iper_pkg::PTR_RESET,
    eff_a: iper_pkg::PTR_RESET, eff_b: iper_pkg::PTR_RESET, eff_c: iper_pkg::PTR_RESET,
    dly: 2'h0, fenv: iper_pkg::FLOAT_ENV_RESET, ienv: iper_pkg::INT_ENV_RESET,
    rdata: 32'h00000000, abs_a: 8'h00, abs_b: 8'h00, abs_c: 8'h00,
    fp_trap: 1'b0, range_trap: 1'b0, prot_trap: 1'b0, bank_viol: 1'b0
  };

  iper_state_s s_q;
  iper_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Operand resolution, one resolver per operand position.

  iper_operand_if op_a ();
  iper_operand_if op_b ();
  iper_operand_if op_c ();

  assign op_a.field = first_source_field;
  assign op_b.field = second_source_field;
  assign op_c.field = destination_field;
  assign op_a.ptr = s_q.eff_a;
  assign op_b.ptr = s_q.eff_b;
  assign op_c.ptr = s_q.eff_c;
  assign op_a.sp_off = stack_offset;
  assign op_b.sp_off = stack_offset;
  assign op_c.sp_off = stack_offset;

  iper_resolve u_res_a (.op(op_a));
  iper_resolve u_res_b (.op(op_b));
  iper_resolve u_res_c (.op(op_c));

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic virt_hit;
  logic prot_hit;
  logic wr_ok;
  logic loads_all;

  always_comb begin
    virt_hit = spr_num >= iper_pkg::SPR_VIRTUAL_FIRST;
    prot_hit = virt_hit || (user_mode && spr_num < iper_pkg::SPR_USER_FIRST);
    wr_ok = spr_access && spr_write && !(user_mode && spr_num < iper_pkg::SPR_USER_FIRST);
    unique case (ptr_load_class)
      iper_pkg::IPER_CLS_SET_POINTERS_INSTR,
      iper_pkg::IPER_CLS_EMULATE,
      iper_pkg::IPER_CLS_FLOAT,
      iper_pkg::IPER_CLS_DIVIDE: loads_all = ptr_load;
      iper_pkg::IPER_CLS_MULTIPLY: loads_all = ptr_load && MUL_LOADS_PTRS;
      default: loads_all = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.abs_a = op_a.abs_num;
    s_d.abs_b = op_b.abs_num;
    s_d.abs_c = op_c.abs_num;
    s_d.prot_trap = spr_access && prot_hit;
    s_d.bank_viol = 1'b0;
    s_d.fp_trap = |(fp_exc_evt
      & ~s_q.fenv[iper_pkg::FE_MASK_HI:0]);
    s_d.range_trap = int_div_zero
      || (int_div_overflow && !s_q.ienv[iper_pkg::IE_DIV_OVF])
      || (int_mul_overflow && !s_q.ienv[iper_pkg::IE_MUL_OVF]);
    if (s_q.dly != 2'h0) begin
      s_d.dly = s_q.dly - 2'h1;
      if (s_q.dly == 2'h1) begin
        s_d.eff_a = s_q.ptr_a;
        s_d.eff_b = s_q.ptr_b;
        s_d.eff_c = s_q.ptr_c;
      end
    end
    if (spr_access && !spr_write) begin
      unique case (spr_num)
        iper_pkg::SPR_RESULT_PTR: s_d.rdata = {22'h000000, s_q.ptr_c, 2'h0};
        iper_pkg::SPR_SOURCE_A_PTR: s_d.rdata = {22'h000000, s_q.ptr_a, 2'h0};
        iper_pkg::SPR_SOURCE_B_PTR: s_d.rdata = {22'h000000, s_q.ptr_b, 2'h0};
        iper_pkg::SPR_FLOAT_ENV: s_d.rdata = {23'h000000, s_q.fenv};
        iper_pkg::SPR_INT_ENV: s_d.rdata = {30'h00000000, s_q.ienv};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (wr_ok) begin
      unique case (spr_num)
        iper_pkg::SPR_RESULT_PTR: begin
          s_d.ptr_c = spr_wdata[iper_pkg::PTR_MSB:iper_pkg::PTR_LSB];
          s_d.dly = DELAY_LOAD;
        end
        iper_pkg::SPR_SOURCE_A_PTR: begin
          s_d.ptr_a = spr_wdata[iper_pkg::PTR_MSB:iper_pkg::PTR_LSB];
          s_d.dly = DELAY_LOAD;
        end
        iper_pkg::SPR_SOURCE_B_PTR: begin
          s_d.ptr_b = spr_wdata[iper_pkg::PTR_MSB:iper_pkg::PTR_LSB];
          s_d.dly = DELAY_LOAD;
        end
        iper_pkg::SPR_FLOAT_ENV: s_d.fenv = spr_wdata[iper_pkg::FE_FAST:0];
        iper_pkg::SPR_INT_ENV: s_d.ienv = spr_wdata[iper_pkg::IE_DIV_OVF:0];
        default: s_d.ptr_a = s_q.ptr_a;
      endcase
    end
    if (loads_all) begin
      s_d.ptr_a = op_a.abs_num;
      s_d.ptr_b = op_b.abs_num;
      s_d.ptr_c = op_c.abs_num;
      s_d.eff_a = op_a.abs_num;
      s_d.eff_b = op_b.abs_num;
      s_d.eff_c = op_c.abs_num;
      s_d.dly = 2'h0;
      s_d.bank_viol = user_mode && (bank_protect[op_a.abs_num[7:4]]
        || bank_protect[op_b.abs_num[7:4]] || bank_protect[op_c.abs_num[7:4]]);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign spr_rdata_q = s_q.rdata;
  assign abs_a_q = s_q.abs_a;
  assign abs_b_q = s_q.abs_b;
  assign abs_c_q = s_q.abs_c;
  assign fast_float_select_q = s_q.fenv[iper_pkg::FE_FAST];
  assign float_round_mode_q = s_q.fenv[iper_pkg::FE_ROUND_HI:iper_pkg::FE_ROUND_LO];
  assign fp_trap_q = s_q.fp_trap;
  assign range_trap_q = s_q.range_trap;
  assign prot_trap_q = s_q.prot_trap;
  assign bank_viol_q = s_q.bank_viol;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_unimpl_write;
    spr_access && spr_write && spr_num == 8'h83 && !loads_all |=> $stable(s_q.ptr_a)
      && $stable(s_q.ptr_b) && $stable(s_q.ptr_c) && $stable(s_q.fenv) && $stable(s_q.ienv);
  endproperty
  a_unimpl_write: assert property (p_unimpl_write)
    else $error("unimplemented write changed state");

  property p_indirect_a;
    first_source_field == 8'h00 |=> abs_a_q == $past(s_q.eff_a);
  endproperty
  a_indirect_a: assert property (p_indirect_a)
    else $error("field zero did not use pointer");

  property p_local_direct;
    destination_field[7] && destination_field != 8'h00 |=>
      abs_c_q == {1'b1, 7'($past(destination_field[6:0]) + $past(stack_offset))};
  endproperty
  a_local_direct: assert property (p_local_direct)
    else $error("local number not offset");

  property p_mts_bits;
    spr_access && spr_write && !user_mode && spr_num == 8'h81 && !loads_all
      |=> s_q.ptr_a == $past(spr_wdata[9:2]);
  endproperty
  a_mts_bits: assert property (p_mts_bits)
    else $error("pointer not from bits 9-2");

  property p_mts_delay;
    spr_access && spr_write && spr_num == 8'h80 && !loads_all && s_q.dly == 2'h0
      ##1 (!loads_all && !(spr_access && spr_write)) [*2] |=> s_q.eff_c == s_q.ptr_c;
  endproperty
  a_mts_delay: assert property (p_mts_delay)
    else $error("pointer write not applied after delay");

  property p_load_all;
    loads_all |=> s_q.eff_b == $past(op_b.abs_num) && s_q.ptr_c == $past(op_c.abs_num);
  endproperty
  a_load_all: assert property (p_load_all)
    else $error("pointers not loaded together");

  property p_bank;
    loads_all && user_mode && bank_protect[op_a.abs_num[7:4]] |=> bank_viol_q;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank violation missed");

  property p_read_zeros;
    spr_access && !spr_write && spr_num == 8'h80 |=>
      spr_rdata_q[1:0] == 2'h0 && spr_rdata_q[31:10] == 22'h000000;
  endproperty
  a_read_zeros: assert property (p_read_zeros)
    else $error("pointer readback not aligned");

  property p_div_zero;
    int_div_zero |=> range_trap_q;
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("divide by zero not trapped");

  property p_fp_div_mask;
    fp_exc_evt == 6'h20 |=> fp_trap_q == !$past(s_q.fenv[5]);
  endproperty
  a_fp_div_mask: assert property (p_fp_div_mask)
    else $error("divide-by-zero mask ignored");

  property p_mul_mask;
    int_mul_overflow && !int_div_zero && !int_div_overflow
      |=> range_trap_q == !$past(s_q.ienv[0]);
  endproperty
  a_mul_mask: assert property (p_mul_mask)
    else $error("multiply mask ignored");

  property p_virtual_trap;
    spr_access && spr_num >= 8'hA0 |=> prot_trap_q;
  endproperty
  a_virtual_trap: assert property (p_virtual_trap)
    else $error("upper register access not trapped");

  property p_indirect_b;
    second_source_field == 8'h00 |=> abs_b_q == $past(s_q.eff_b);
  endproperty
  a_indirect_b: assert property (p_indirect_b)
    else $error("second source field zero did not use its pointer");

  property p_indirect_c;
    destination_field == 8'h00 |=> abs_c_q == $past(s_q.eff_c);
  endproperty
  a_indirect_c: assert property (p_indirect_c)
    else $error("destination field zero did not use its pointer");

  property p_global_direct;
    first_source_field != 8'h00 && !first_source_field[7]
      |=> abs_a_q == $past(first_source_field);
  endproperty
  a_global_direct: assert property (p_global_direct)
    else $error("global number not passed unchanged");

  property p_user_prot;
    spr_access && user_mode && spr_num < 8'h80 |=> prot_trap_q;
  endproperty
  a_user_prot: assert property (p_user_prot)
    else $error("user access to protected register not trapped");

  property p_unprot_open;
    spr_access && spr_num >= 8'h80 && spr_num < 8'hA0 |=> !prot_trap_q;
  endproperty
  a_unprot_open: assert property (p_unprot_open)
    else $error("unprotected register access trapped");

  property p_div_ovf_mask;
    int_div_overflow && !int_div_zero && !int_mul_overflow
      |=> range_trap_q == !$past(s_q.ienv[1]);
  endproperty
  a_div_ovf_mask: assert property (p_div_ovf_mask)
    else $error("divide overflow mask ignored");

  property p_env_reserved;
    spr_access && !spr_write && spr_num == 8'hA0 |=> spr_rdata_q[31:9] == 23'h000000;
  endproperty
  a_env_reserved: assert property (p_env_reserved)
    else $error("float environment reserved bits not zero");

  c_mts_pointer: cover property (spr_access && spr_write && spr_num == 8'h82
    ##3 s_q.eff_b == s_q.ptr_b);
  c_load_all: cover property (loads_all ##1 first_source_field == 8'h00);
  c_range_trap: cover property (int_div_overflow ##1 range_trap_q);
  c_user_trap: cover property (spr_access && user_mode && spr_num < 8'h80 ##1 prot_trap_q);
  c_fp_trap: cover property (fp_exc_evt[5] ##1 fp_trap_q);

endmodule

// ---- tb/iper_decode_model.sv ----
// Decode stage model: issues operand fields and pointer-loading instructions.
// Assumes the bench calls step once per cycle; signals change at the falling edge.
`timescale 1ns/10ps
module iper_decode_model (
  input wire logic core_clk,
  output logic ptr_load,
  output iper_pkg::iper_class_e ptr_load_class,
  output logic [7:0] first_source_field,
  output logic [7:0] second_source_field,
  output logic [7:0] destination_field,
  output logic [6:0] stack_offset
);
  initial begin
    ptr_load = 1'b0;
    ptr_load_class = iper_pkg::IPER_CLS_NONE;
    first_source_field = 8'h01;
    second_source_field = 8'h01;
    destination_field = 8'h01;
    stack_offset = 7'h00;
  end
  task automatic step(input logic ld, input iper_pkg::iper_class_e cls, input logic [7:0] a,
                      input logic [7:0] b, input logic [7:0] c, input logic [6:0] so);
    @(negedge core_clk);
    ptr_load = ld;
    ptr_load_class = cls;
    first_source_field = a;
    second_source_field = b;
    destination_field = c;
    stack_offset = so;
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the pointer and environment block.
// Assumes the design package is compiled first; drives inputs at the falling edge.
`timescale 1ns/10ps
module testbench;
  localparam int DLY = 2;
  logic core_clk, rst, spr_access, spr_write, user_mode, dov, dz, mov;
  logic [7:0] spr_num;
  logic [31:0] spr_wdata, rd, d;
  logic [15:0] bank_protect;
  logic [5:0] ev;
  logic ptr_load, tr, bv, ld;
  iper_pkg::iper_class_e cls, dcls;
  logic [7:0] fa, fb, fc, p[3], q[3], abs_a_q, abs_b_q, abs_c_q;
  logic [6:0] so, stack_offset;
  logic [8:0] fm;
  logic [1:0] im, float_round_mode;
  logic [31:0] spr_rdata_q;
  logic fast_q, fp_trap_q, range_trap_q, prot_trap_q, bank_viol_q;
  logic [7:0] a_f, b_f, c_f;
  integer seed = 32'h44BFF171;
  int n_errors = 0, n_checks = 0, cyc = 0;
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  iper_decode_model u_dec (.core_clk(core_clk), .ptr_load(ptr_load), .ptr_load_class(dcls),
    .first_source_field(a_f), .second_source_field(b_f), .destination_field(c_f),
    .stack_offset(stack_offset));
  iper_top #(.MTS_DELAY(DLY), .MUL_LOADS_PTRS(1'b0)) dut (.core_clk(core_clk), .rst(rst),
    .spr_access(spr_access), .spr_write(spr_write), .spr_num(spr_num), .spr_wdata(spr_wdata),
    .user_mode(user_mode), .ptr_load(ptr_load), .ptr_load_class(dcls),
    .first_source_field(a_f), .second_source_field(b_f), .destination_field(c_f),
    .stack_offset(stack_offset), .bank_protect(bank_protect), .fp_exc_evt(ev),
    .int_div_overflow(dov), .int_div_zero(dz), .int_mul_overflow(mov),
    .spr_rdata_q(spr_rdata_q), .abs_a_q(abs_a_q), .abs_b_q(abs_b_q), .abs_c_q(abs_c_q),
    .fast_float_select_q(fast_q), .float_round_mode_q(float_round_mode), .fp_trap_q(fp_trap_q),
    .range_trap_q(range_trap_q), .prot_trap_q(prot_trap_q), .bank_viol_q(bank_viol_q));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic spr(input logic w, input logic [7:0] n, input logic [31:0] wd);
    @(negedge core_clk);
    spr_access = 1'b1;
    spr_write = w;
    spr_num = n;
    spr_wdata = wd;
    @(negedge core_clk);
    spr_access = 1'b0;
    rd = spr_rdata_q;
    tr = prot_trap_q;
  endtask
  function automatic logic [7:0] res(input logic [7:0] f, input logic [7:0] pv,
                                     input logic [6:0] s);
    if (f == 8'h00) return pv;
    if (f[7]) return {1'b1, f[6:0] + s};
    return f;
  endfunction
  function automatic logic [7:0] rfld();
    if (($random(seed) & 3) == 0) return 8'h00;
    return 8'($random(seed));
  endfunction
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {spr_access, spr_write, user_mode, dov, dz, mov} = 6'h00;
    spr_num = 8'h00;
    spr_wdata = 32'h0;
    bank_protect = 16'h0;
    ev = 6'h00;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      spr(1'b0, iper_pkg::SPR_RESULT_PTR + 8'(i), 32'h0);
      chk(rd, 32'h0, "pointer reset");
      d = $random(seed);
      spr(1'b1, iper_pkg::SPR_RESULT_PTR + 8'(i), d | 32'hFFFF_FC03);
      p[i] = d[9:2];
      spr(1'b0, iper_pkg::SPR_RESULT_PTR + 8'(i), 32'h0);
      chk(rd, {22'h0, p[i], 2'h0}, "pointer readback");
    end
    spr(1'b1, 8'h83, 32'hFFFF_FFFF);
    spr(1'b0, 8'h83, 32'h0);
    spr(1'b0, iper_pkg::SPR_RESULT_PTR, 32'h0);
    chk(rd, {22'h0, p[0], 2'h0}, "unimplemented write");
    user_mode = 1'b1;
    spr(1'b0, 8'h05, 32'h0);
    chk_bit(tr, 1'b1, "user protected");
    spr(1'b1, iper_pkg::SPR_SOURCE_A_PTR, 32'h0);
    chk_bit(tr, 1'b0, "user unprotected");
    p[1] = 8'h00;
    spr(1'b1, iper_pkg::SPR_INT_ENV, 32'h0);
    chk_bit(tr, 1'b1, "virtual number");
    user_mode = 1'b0;
    q[1] = p[1];
    spr(1'b1, iper_pkg::SPR_SOURCE_A_PTR, 32'h0000_0214);
    p[1] = 8'h85;
    for (int k = 0; k < DLY + 1; k++) begin
      u_dec.step(1'b0, iper_pkg::IPER_CLS_NONE, 8'h00, 8'h11, 8'h12, 7'h05);
      @(posedge core_clk);
      #1 chk(abs_a_q, (k < DLY - 1) ? q[1] : p[1], "delayed pointer");
    end
    repeat (200) begin
      fa = rfld();
      fb = rfld();
      fc = rfld();
      so = 7'($random(seed));
      u_dec.step(1'b0, iper_pkg::IPER_CLS_NONE, fa, fb, fc, so);
      @(posedge core_clk);
      #1 chk(abs_a_q, res(fa, p[1], so), "abs a");
      chk(abs_b_q, res(fb, p[2], so), "abs b");
      chk(abs_c_q, res(fc, p[0], so), "abs c");
    end
    for (int r = 0; r < 15; r++) begin
      cls = iper_pkg::iper_class_e'(3'(1 + r % 5));
      ld = (cls != iper_pkg::IPER_CLS_MULTIPLY);
      fa = 8'($random(seed)) | 8'h02;
      fb = 8'($random(seed)) | 8'h02;
      fc = 8'($random(seed)) | 8'h02;
      so = 7'($random(seed));
      user_mode = 1'($random(seed));
      bank_protect = 16'($random(seed));
      q[0] = res(fc, p[0], so);
      q[1] = res(fa, p[1], so);
      q[2] = res(fb, p[2], so);
      bv = ld & user_mode;
      bv = bv & (bank_protect[q[0][7:4]] | bank_protect[q[1][7:4]] | bank_protect[q[2][7:4]]);
      u_dec.step(1'b1, cls, fa, fb, fc, so);
      @(posedge core_clk);
      #1 chk_bit(bank_viol_q, bv, "bank check");
      u_dec.step(1'b0, iper_pkg::IPER_CLS_NONE, 8'h00, 8'h01, 8'h01, 7'h00);
      user_mode = 1'b0;
      @(posedge core_clk);
      #1 chk(abs_a_q, ld ? q[1] : p[1], "loaded pointer in use");
      for (int i = 0; i < 3; i++) begin
        if (ld) p[i] = q[i];
        spr(1'b0, iper_pkg::SPR_RESULT_PTR + 8'(i), 32'h0);
        chk(rd, {22'h0, p[i], 2'h0}, "loaded pointer");
      end
    end
    for (int r = 0; r < 40; r++) begin
      fm = 9'($random(seed));
      fm[7:6] = 2'(r);
      // The first two passes send a lone divide-by-zero event against both mask values.
      if (r < 2) fm[5] = r[0];
      im = (r % 8 == 0) ? 2'h1 : 2'($random(seed));
      spr(1'b1, iper_pkg::SPR_FLOAT_ENV, {23'h7FFFFF, fm});
      spr(1'b1, iper_pkg::SPR_INT_ENV, {30'h0, im});
      chk_bit(fast_q, fm[8], "fast select");
      chk(float_round_mode, fm[7:6], "round mode");
      spr(1'b0, iper_pkg::SPR_FLOAT_ENV, 32'h0);
      chk(rd, {23'h0, fm}, "float env readback");
      @(negedge core_clk);
      ev = 6'($random(seed));
      if (r < 2) ev = 6'h20;
      {dov, dz, mov} = 3'($random(seed));
      @(negedge core_clk);
      chk_bit(fp_trap_q, |(ev & ~fm[5:0]), "float trap");
      chk_bit(range_trap_q, dz | (dov & ~im[1]) | (mov & ~im[0]),
        "range");
      ev = 6'h00;
      {dov, dz, mov} = 3'h0;
    end
    print_verdict();
  end
endmodule
